/* rtl/smph_top.sv */
// Target-side message phase handler for a parallel SCSI bus
`timescale 1ns/1ps
`default_nettype none
module smph_top #(
	parameter int unsigned DISC_DELAY_CYC = smph_pkg::DISC_DELAY_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        en_i,
	input  wire logic        atn_i,
	input  wire logic        ack_i,
	input  wire logic        bus_rst_i,
	output logic             req_o,
	output logic             bsy_o,
	output logic             msg_in_o,
	output logic [7:0]       data_o,
	input  wire logic        msg_out_vld_i,
	input  wire logic [7:0]  msg_out_byte_i,
	input  wire logic        sel_i,
	input  wire logic        resel_i,
	input  wire logic [3:0]  resel_key_i,
	input  wire logic        cmd_done_i,
	input  wire logic        disc_req_i,
	input  wire logic        save_ptr_i,
	input  wire logic        disc_ok_i,
	input  wire logic [2:0]  ext_sup_i,
	input  wire logic [31:0] disc_limit_i,
	output logic             req_rdy_o,
	output logic             clr_nexus_o,
	output logic             clr_task_o,
	output logic             clr_all_o,
	output logic             clr_unit_o,
	output logic             ua_all_o,
	output logic             ua_cleared_o,
	output logic             unexp_o,
	output logic             ext_vld_o,
	output logic [7:0]       ext_code_o,
	output logic             arb_inhibit_o
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [3:0] id_key(input logic [7:0] b);
		id_key = {b[smph_pkg::ID_TAR_POS], b[smph_pkg::ID_UNIT_MSB:0]};
	endfunction : id_key

	function automatic logic ext_sup(input logic [7:0] c, input logic [2:0] m);
		ext_sup = ((c == smph_pkg::EXT_MOD_PTR) && m[0]) ||
			((c == smph_pkg::EXT_SYNC_NEG) && m[1]) ||
			((c == smph_pkg::EXT_WIDE_NEG) && m[2]);
	endfunction : ext_sup

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] sync_q1;
	logic [2:0] sync_q2;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync_q1 <= smph_pkg::SYNC_RST;
			sync_q2 <= smph_pkg::SYNC_RST;
		end else if (en_i) begin
			sync_q1 <= {bus_rst_i, ack_i, atn_i};
			sync_q2 <= sync_q1;
		end
	end

	logic atn_s;
	logic ack_s;
	logic rst_s;
	assign atn_s = sync_q2[0];
	assign ack_s = sync_q2[1];
	assign rst_s = sync_q2[2];

	// ----------------------------------------------------------------
	// State and decode
	// ----------------------------------------------------------------
	smph_pkg::smph_state_e state;
	smph_pkg::smph_state_e next_state;
	logic [3:0]                  unit_key;
	logic                        id_valid;
	logic                        full_id;
	logic                        bsy;
	logic [7:0]                  tx_b1;
	logic [1:0]                  tx_n;
	logic [31:0]                 hold_cnt;
	logic [smph_pkg::ACT_W-1:0]  act;
	logic [3:0]                  next_unit_key;
	logic                        next_id_valid;
	logic                        next_full_id;
	logic                        next_bsy;
	logic [7:0]                  next_tx_b0;
	logic [7:0]                  next_tx_b1;
	logic [1:0]                  next_tx_n;
	logic [31:0]                 next_hold_cnt;
	logic [smph_pkg::ACT_W-1:0]  next_act;
	logic                        next_unexp;
	logic                        next_ext_vld;
	logic [7:0]                  next_ext_code;

	smph_ext_if ext ();

	logic rx;
	logic is_id;
	logic bad_key;
	logic first_ok;
	logic ext_ok;
	logic tx_end;
	logic [31:0] hold_len;

	assign rx       = msg_out_vld_i && ((state == smph_pkg::S_FIRST) || (state == smph_pkg::S_CONN));
	assign is_id    = msg_out_byte_i[smph_pkg::ID_FLAG_POS];
	assign bad_key  = id_valid && (id_key(msg_out_byte_i) != unit_key);
	assign first_ok = is_id || (msg_out_byte_i == smph_pkg::MSG_ABORT) || (msg_out_byte_i == smph_pkg::MSG_BDR);
	assign ext_ok   = ext_sup(ext.code, ext_sup_i);
	assign tx_end   = (state == smph_pkg::S_TX_ACK) && !ack_s && (tx_n == 2'd1);
	assign hold_len = (DISC_DELAY_CYC > disc_limit_i) ? DISC_DELAY_CYC : disc_limit_i;

	assign ext.start = rx && !is_id && (msg_out_byte_i == smph_pkg::MSG_EXT) && !(state == smph_pkg::S_FIRST);
	assign ext.abort = rst_s;
	assign ext.vld   = msg_out_vld_i && (state == smph_pkg::S_EXT);
	assign ext.data  = msg_out_byte_i;

	assign req_o         = (state == smph_pkg::S_TX_REQ);
	assign msg_in_o      = (state == smph_pkg::S_TX_REQ) || (state == smph_pkg::S_TX_ACK);
	assign req_rdy_o     = (state == smph_pkg::S_CONN) && !rx;
	assign arb_inhibit_o = (state == smph_pkg::S_HOLD);
	assign bsy_o         = bsy;
	assign clr_nexus_o   = act[smph_pkg::ACT_NEXUS];
	assign clr_task_o    = act[smph_pkg::ACT_TASK];
	assign clr_all_o     = act[smph_pkg::ACT_ALL];
	assign clr_unit_o    = act[smph_pkg::ACT_UNIT];
	assign ua_all_o      = act[smph_pkg::ACT_UA_ALL];
	assign ua_cleared_o  = act[smph_pkg::ACT_UA_CLR];

	smph_ext_parser u_ext (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.en_i   (en_i),
		.ext    (ext.parser)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic       go_free;
		logic       ld;
		logic [7:0] ld0;
		logic [7:0] ld1;
		logic [1:0] ldn;
		go_free       = 1'b0;
		ld            = 1'b0;
		ld0           = smph_pkg::MSG_REJECT;
		ld1           = smph_pkg::MSG_REJECT;
		ldn           = 2'd1;
		next_state    = state;
		next_unit_key = unit_key;
		next_id_valid = id_valid;
		next_full_id  = full_id;
		next_bsy      = bsy;
		next_tx_b0    = data_o;
		next_tx_b1    = tx_b1;
		next_tx_n     = tx_n;
		next_hold_cnt = hold_cnt;
		next_act      = smph_pkg::ACT_RST;
		next_unexp    = 1'b0;
		next_ext_vld  = 1'b0;
		next_ext_code = ext_code_o;
		case (state)
			smph_pkg::S_IDLE: begin
				if (sel_i) begin
					next_state    = smph_pkg::S_FIRST;
					next_bsy      = 1'b1;
					next_id_valid = 1'b0;
					next_full_id  = 1'b0;
				end else if (resel_i) begin
					// Reconnection starts with our own identify
					ld            = 1'b1;
					ld0           = {1'b1, 1'b0, resel_key_i[3], 2'b00, resel_key_i[2:0]};
					next_bsy      = 1'b1;
					next_unit_key = resel_key_i;
					next_id_valid = 1'b1;
					next_full_id  = 1'b0;
				end
			end
			smph_pkg::S_FIRST, smph_pkg::S_CONN: begin
				if (rx) begin
					if ((state == smph_pkg::S_FIRST) && !first_ok) begin
						go_free    = 1'b1;
						next_unexp = 1'b1;
					end else if (is_id) begin
						if (bad_key) begin
							go_free    = 1'b1;
							next_unexp = 1'b1;
						end else begin
							next_unit_key = id_key(msg_out_byte_i);
							next_id_valid = 1'b1;
							next_full_id  = 1'b1;
							next_state    = smph_pkg::S_CONN;
						end
					end else begin
						// None of these touch mode, reservation or allegiance state
						case (msg_out_byte_i)
							smph_pkg::MSG_EXT: next_state = smph_pkg::S_EXT;
							smph_pkg::MSG_ABORT: begin
								go_free = 1'b1;
								next_act[smph_pkg::ACT_NEXUS] = id_valid;
							end
							smph_pkg::MSG_ABORT_TAG: begin
								go_free = 1'b1;
								next_act[smph_pkg::ACT_TASK] = full_id;
							end
							smph_pkg::MSG_BDR: begin
								go_free = 1'b1;
								next_act[smph_pkg::ACT_ALL]    = 1'b1;
								next_act[smph_pkg::ACT_UA_ALL] = 1'b1;
							end
							smph_pkg::MSG_CLR_Q: begin
								go_free = 1'b1;
								next_act[smph_pkg::ACT_UNIT]   = 1'b1;
								next_act[smph_pkg::ACT_UA_CLR] = 1'b1;
							end
							smph_pkg::MSG_DISC: begin
								ld  = 1'b1;
								ld0 = disc_ok_i ? (save_ptr_i ? smph_pkg::MSG_SAVE_PTR : smph_pkg::MSG_DISC)
									: smph_pkg::MSG_REJECT;
								ld1 = smph_pkg::MSG_DISC;
								ldn = (disc_ok_i && save_ptr_i) ? 2'd2 : 2'd1;
							end
							default: ;
						endcase
					end
				end else if ((state == smph_pkg::S_CONN) && cmd_done_i) begin
					ld  = 1'b1;
					ld0 = smph_pkg::MSG_CMD_DONE;
				end else if ((state == smph_pkg::S_CONN) && disc_req_i) begin
					ld  = 1'b1;
					ld0 = smph_pkg::MSG_SAVE_PTR;
					ld1 = smph_pkg::MSG_DISC;
					ldn = 2'd2;
				end
			end
			smph_pkg::S_EXT: begin
				if (ext.done) begin
					if (ext_ok) begin
						next_ext_vld  = 1'b1;
						next_ext_code = ext.code;
						next_state    = smph_pkg::S_CONN;
					end else begin
						ld = 1'b1;
					end
				end
			end
			smph_pkg::S_TX_REQ: begin
				if (ack_s) begin
					next_state = smph_pkg::S_TX_ACK;
				end
			end
			smph_pkg::S_TX_ACK: begin
				if (!ack_s) begin
					if (tx_n == 2'd2) begin
						next_tx_b0 = tx_b1;
						next_tx_n  = 2'd1;
						next_state = smph_pkg::S_TX_REQ;
					end else if (((data_o == smph_pkg::MSG_CMD_DONE) || (data_o == smph_pkg::MSG_DISC)) && !atn_s) begin
						go_free = 1'b1;
					end else begin
						// Attention raised after complete or disconnect, or any other byte sent: back to S_CONN for message out
						if (data_o[smph_pkg::ID_FLAG_POS]) begin
							next_full_id = !atn_s;
						end
						next_state = smph_pkg::S_CONN;
					end
				end
			end
			smph_pkg::S_HOLD: begin
				if (hold_cnt == smph_pkg::HOLD_RST) begin
					next_state = smph_pkg::S_IDLE;
				end else begin
					next_hold_cnt = hold_cnt - 32'h0000_0001;
				end
			end
			default: next_state = smph_pkg::S_IDLE;
		endcase
		if (ld) begin
			next_tx_b0 = ld0;
			next_tx_b1 = ld1;
			next_tx_n  = ldn;
			next_state = smph_pkg::S_TX_REQ;
		end
		if (go_free) begin
			next_state    = smph_pkg::S_IDLE;
			next_bsy      = 1'b0;
			next_id_valid = 1'b0;
			next_full_id  = 1'b0;
			if (tx_end && (data_o == smph_pkg::MSG_DISC)) begin
				next_state    = smph_pkg::S_HOLD;
				next_hold_cnt = hold_len;
			end
		end
		// Bus reset wins over the state, busy, identify, hold and action updates and lands in bus free
		if (rst_s) begin
			next_state    = smph_pkg::S_IDLE;
			next_bsy      = 1'b0;
			next_id_valid = 1'b0;
			next_full_id  = 1'b0;
			next_hold_cnt = smph_pkg::HOLD_RST;
			next_act      = smph_pkg::ACT_RST;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state      <= smph_pkg::S_IDLE;
			unit_key   <= 4'h0;
			id_valid   <= 1'b0;
			full_id    <= 1'b0;
			bsy        <= 1'b0;
			data_o     <= 8'h00;
			tx_b1      <= 8'h00;
			tx_n       <= 2'd0;
			hold_cnt   <= smph_pkg::HOLD_RST;
			act        <= smph_pkg::ACT_RST;
			unexp_o    <= 1'b0;
			ext_vld_o  <= 1'b0;
			ext_code_o <= 8'h00;
		end else if (en_i) begin
			state      <= next_state;
			unit_key   <= next_unit_key;
			id_valid   <= next_id_valid;
			full_id    <= next_full_id;
			bsy        <= next_bsy;
			data_o     <= next_tx_b0;
			tx_b1      <= next_tx_b1;
			tx_n       <= next_tx_n;
			hold_cnt   <= next_hold_cnt;
			act        <= next_act;
			unexp_o    <= next_unexp;
			ext_vld_o  <= next_ext_vld;
			ext_code_o <= next_ext_code;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	logic go;
	logic conn_rx;
	assign go      = en_i && !rst_s;
	assign conn_rx = go && (state == smph_pkg::S_CONN) && rx;

	AST_FIRST_MSG: assert property (go && (state == smph_pkg::S_FIRST) && rx && !first_ok
		|=> (state == smph_pkg::S_IDLE) && unexp_o && !bsy_o) else $error("bad first message kept bus");
	AST_RESEL_ID: assert property (go && (state == smph_pkg::S_IDLE) && !sel_i && resel_i
		|=> req_o && data_o[7] && (data_o[3:0] == {1'b0, $past(resel_key_i[2:0])})) else $error("no identify");
	AST_ID_SWITCH: assert property (conn_rx && is_id && bad_key |=> !bsy_o && unexp_o)
		else $error("unit switch kept bus");
	AST_ABORT: assert property (conn_rx && (msg_out_byte_i == smph_pkg::MSG_ABORT)
		|=> (clr_nexus_o == $past(id_valid)) && !bsy_o && !msg_in_o) else $error("abort mishandled");
	AST_ABT_TAG: assert property (conn_rx && (msg_out_byte_i == smph_pkg::MSG_ABORT_TAG)
		|=> (clr_task_o == $past(full_id)) && !clr_nexus_o && !bsy_o) else $error("abort tag mishandled");
	AST_BDR: assert property (conn_rx && (msg_out_byte_i == smph_pkg::MSG_BDR)
		|=> clr_all_o && ua_all_o && !bsy_o) else $error("device reset mishandled");
	AST_CLR_Q: assert property (conn_rx && (msg_out_byte_i == smph_pkg::MSG_CLR_Q)
		|=> clr_unit_o && ua_cleared_o && !ua_all_o && !bsy_o) else $error("clear queue mishandled");
	AST_CC_DONE: assert property (go && tx_end && (data_o == smph_pkg::MSG_CMD_DONE) && !atn_s
		|=> !bsy_o && !arb_inhibit_o && (state == smph_pkg::S_IDLE)) else $error("busy kept after complete");
	AST_DISC_OUT: assert property (go && tx_end && (data_o == smph_pkg::MSG_DISC) && !atn_s
		|=> !bsy_o && arb_inhibit_o) else $error("disconnect not followed by hold");
	AST_HOLD: assert property (go && (state == smph_pkg::S_HOLD) && (hold_cnt != 32'h0000_0000)
		|=> arb_inhibit_o) else $error("arbitration hold ended early");
	AST_SPLIT: assert property (go && req_rdy_o && !cmd_done_i && disc_req_i
		|=> (data_o == smph_pkg::MSG_SAVE_PTR) && (tx_b1 == smph_pkg::MSG_DISC) && (tx_n == 2'd2))
		else $error("split end not save then disconnect");
	AST_DISC_IN: assert property (conn_rx && (msg_out_byte_i == smph_pkg::MSG_DISC) && !disc_ok_i
		|=> msg_in_o && (data_o == smph_pkg::MSG_REJECT)) else $error("refused disconnect not rejected");
	AST_EXT_REJ: assert property (go && (state == smph_pkg::S_EXT) && ext.done && !ext_ok
		|=> (data_o == smph_pkg::MSG_REJECT) && !ext_vld_o ##1 req_o) else $error("bad extended not rejected");

	COV_CC: cover property (go && tx_end && (data_o == smph_pkg::MSG_CMD_DONE) && !atn_s);
	COV_HOLD: cover property (go && (state == smph_pkg::S_HOLD) && (hold_cnt == 32'h0000_0000));
	COV_EXT: cover property (ext_vld_o);
	COV_ABORT: cover property (clr_nexus_o);

endmodule : smph_top
`default_nettype wire

/* rtl/smph_pkg.sv */
// Shared constants and types for the message phase handler
package smph_pkg;

	// ----------------------------------------------------------------
	// Message codes
	// ----------------------------------------------------------------
	localparam logic [7:0] MSG_CMD_DONE  = 8'h00;
	localparam logic [7:0] MSG_EXT       = 8'h01;
	localparam logic [7:0] MSG_SAVE_PTR  = 8'h02;
	localparam logic [7:0] MSG_DISC      = 8'h04;
	localparam logic [7:0] MSG_ABORT     = 8'h06;
	localparam logic [7:0] MSG_REJECT    = 8'h07;
	localparam logic [7:0] MSG_BDR       = 8'h0c;
	localparam logic [7:0] MSG_ABORT_TAG = 8'h0d;
	localparam logic [7:0] MSG_CLR_Q     = 8'h0e;

	// ----------------------------------------------------------------
	// Extended message codes and layout
	// ----------------------------------------------------------------
	localparam logic [7:0] EXT_MOD_PTR  = 8'h00;
	localparam logic [7:0] EXT_SYNC_NEG = 8'h01;
	localparam logic [7:0] EXT_WIDE_NEG = 8'h03;
	localparam logic [8:0] EXT_LEN_ZERO = 9'h100;
	localparam logic [8:0] EXT_LEN_RST  = 9'h000;

	// ----------------------------------------------------------------
	// Identify byte fields
	// ----------------------------------------------------------------
	localparam int ID_FLAG_POS  = 7;
	localparam int ID_TAR_POS   = 5;
	localparam int ID_UNIT_MSB  = 2;

	// ----------------------------------------------------------------
	// Action pulse positions and reset values
	// ----------------------------------------------------------------
	localparam int ACT_NEXUS   = 0;
	localparam int ACT_TASK    = 1;
	localparam int ACT_ALL     = 2;
	localparam int ACT_UNIT    = 3;
	localparam int ACT_UA_ALL  = 4;
	localparam int ACT_UA_CLR  = 5;
	localparam int ACT_W       = 6;
	localparam logic [ACT_W-1:0] ACT_RST  = 6'h00;
	localparam logic [2:0]       SYNC_RST = 3'h0;
	localparam logic [31:0]      HOLD_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 25;
	localparam int unsigned DISC_DELAY_NS  = 250000;
	localparam int unsigned DISC_DELAY_CYC = (DISC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		S_IDLE,
		S_FIRST,
		S_CONN,
		S_EXT,
		S_TX_REQ,
		S_TX_ACK,
		S_HOLD
	} smph_state_e;

endpackage : smph_pkg

/* rtl/smph_ext_if.sv */
// Carrier between the handler and its extended message parser
`timescale 1ns/1ps
`default_nettype none
interface smph_ext_if;
	logic       start;
	logic       abort;
	logic       vld;
	logic [7:0] data;
	logic       done;
	logic [7:0] code;

	modport host   (output start, output abort, output vld, output data, input done, input code);
	modport parser (input start, input abort, input vld, input data, output done, output code);
endinterface : smph_ext_if
`default_nettype wire

/* rtl/smph_ext_parser.sv */
// Extended message parser: length byte, code byte, argument bytes
`timescale 1ns/1ps
`default_nettype none
module smph_ext_parser (
	input  wire logic    clk_i,
	input  wire logic    rstn_i,
	input  wire logic    en_i,
	smph_ext_if.parser   ext
);

	logic       busy;
	logic       have_len;
	logic       first;
	logic       done;
	logic [7:0] code;
	logic [8:0] remain;
	logic [8:0] lenv;
	logic [8:0] seen;
	logic [8:0] len_dec;

	// Zero length means 256 bytes follow
	assign len_dec  = (ext.data == 8'h00) ? smph_pkg::EXT_LEN_ZERO : {1'b0, ext.data};
	assign ext.done = done;
	assign ext.code = code;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy     <= 1'b0;
			have_len <= 1'b0;
			first    <= 1'b0;
			done     <= 1'b0;
			code     <= 8'h00;
			remain   <= smph_pkg::EXT_LEN_RST;
			lenv     <= smph_pkg::EXT_LEN_RST;
			seen     <= smph_pkg::EXT_LEN_RST;
		end else if (en_i) begin
			done <= 1'b0;
			if (ext.abort) begin
				busy <= 1'b0;
			end else if (ext.start) begin
				busy     <= 1'b1;
				have_len <= 1'b0;
				seen     <= smph_pkg::EXT_LEN_RST;
			end else if (busy && ext.vld) begin
				if (!have_len) begin
					remain   <= len_dec;
					lenv     <= len_dec;
					have_len <= 1'b1;
					first    <= 1'b1;
				end else begin
					if (first) begin
						code <= ext.data;
					end
					first  <= 1'b0;
					seen   <= seen + 9'h001;
					remain <= remain - 9'h001;
					if (remain == 9'h001) begin
						busy <= 1'b0;
						done <= 1'b1;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_EXT_LEN: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(done) |-> (seen == lenv) && (lenv != 9'h000))
		else $error("extended message ended at wrong byte count");

endmodule : smph_ext_parser
`default_nettype wire

/* verif/smph_init_model.sv */
// Initiator model answering the target's message-in handshake
`timescale 1ns/1ps
`default_nettype none
module smph_init_model (
	input  wire logic       clk_i,
	input  wire logic       req_i,
	input  wire logic       atn_i,
	input  wire logic [3:0] slow_i,
	output logic            ack_o,
	output logic            atn_o
);
	// Attention follows the bench; while true an inbound byte is still acknowledged like any other
	// No pointers kept; nothing saved on a received disconnect
	// No queue tag is ever sent, so none can stray from its identify
	assign atn_o = atn_i;
	initial begin
		ack_o = 1'b0;
		forever begin
			@(posedge clk_i);
			if (req_i) begin
				repeat (slow_i) @(posedge clk_i);
				#2 ack_o = 1'b1;
				while (req_i) @(posedge clk_i);
				#2 ack_o = 1'b0;
			end
		end
	end
endmodule : smph_init_model
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the message phase handler
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int unsigned DLY = 8;
	logic        clk_i, rstn_i, bus_rst, vld, sel, resel, en, atn_r;
	logic        cmd, dreq, sptr, dok, req_q = 1'b0;
	logic        atn, ack, req, bsy, min, rdy, evld, inh;
	logic [7:0]  mbyte, dout, ecode, pulse;
	logic [3:0]  key, slow;
	logic [2:0]  sup;
	logic [31:0] lim, lfsr = 32'h77657286;
	logic [8:0]  q[$];
	logic [8:0]  exp_e;
	int          err_count = 0, samples_checked = 0, n;

	always #12.5 clk_i = ~clk_i;

	smph_top #(.DISC_DELAY_CYC(DLY)) i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .en_i(en), .atn_i(atn), .ack_i(ack),
		.bus_rst_i(bus_rst), .req_o(req), .bsy_o(bsy), .msg_in_o(min), .data_o(dout), .msg_out_vld_i(vld),
		.msg_out_byte_i(mbyte), .sel_i(sel), .resel_i(resel), .resel_key_i(key), .cmd_done_i(cmd),
		.disc_req_i(dreq), .save_ptr_i(sptr), .disc_ok_i(dok), .ext_sup_i(sup), .disc_limit_i(lim),
		.req_rdy_o(rdy), .clr_nexus_o(pulse[0]), .clr_task_o(pulse[1]), .clr_all_o(pulse[2]),
		.clr_unit_o(pulse[3]), .ua_all_o(pulse[4]), .ua_cleared_o(pulse[5]), .unexp_o(pulse[7]),
		.ext_vld_o(pulse[6]), .ext_code_o(ecode), .arb_inhibit_o(inh));
	assign evld = pulse[6];
	smph_init_model i_init (.clk_i(clk_i), .req_i(req), .atn_i(atn_r), .slow_i(slow), .ack_o(ack), .atn_o(atn));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#2;
	endtask : tick
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	// Back to back bytes keep the strobe up instead of dropping and raising it at once
	task automatic send(input logic [7:0] b, input bit last = 1'b1);
		vld = 1'b1;
		mbyte = b;
		tick(1);
		if (last) begin
			vld = 1'b0;
			mbyte = ~b;
		end
	endtask : send
	task automatic wait_on(input int which);
		n = 0;
		while (((which == 0) ? (bsy || inh || req) : (which == 1) ? !rdy : (which == 2) ? !inh : inh) && n < 3000) begin
			tick(1);
			n++;
		end
		if (n >= 3000) begin
			err_count++;
			end_of_test();
		end
	endtask : wait_on
	task automatic connect(input logic r);
		lfsr = nxt(lfsr);
		slow = {2'b00, lfsr[1:0]};
		key = lfsr[7:4];
		sel = !r;
		resel = r;
		tick(1);
		sel = 1'b0;
		resel = 1'b0;
	endtask : connect

	// ----------------------------------------------------------------
	// Result watcher
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		req_q <= req;
		// Outputs are unknown before the first reset edge
		if (rstn_i && (pulse !== 8'h00 || (req && !req_q))) begin
			exp_e = (q.size() > 0) ? q.pop_front() : 9'h1ff;
			chk(exp_e === ((pulse !== 8'h00) ? {1'b0, pulse} : {1'b1, dout}), "event mismatch");
			if (evld) chk(ecode === smph_pkg::EXT_WIDE_NEG, "extended code");
		end
	end

	initial begin
		logic [7:0] act_m [4] = '{smph_pkg::MSG_ABORT, smph_pkg::MSG_ABORT_TAG, smph_pkg::MSG_BDR, smph_pkg::MSG_CLR_Q};
		logic [7:0] act_p [4] = '{8'h01, 8'h02, 8'h14, 8'h28};
		{clk_i, rstn_i, bus_rst, vld, sel, resel, cmd, dreq, sptr, dok, atn_r} = 11'h000;
		en = 1'b1;
		sup = 3'h4;
		mbyte = 8'h00;
		key = 4'h0;
		slow = 4'h0;
		lim = 32'h0;
		tick(3);
		rstn_i = 1'b1;
		connect(0); q.push_back(9'h080); send(8'h55); wait_on(0);
		connect(0); send(smph_pkg::MSG_ABORT); wait_on(0);
		for (int i = 0; i < 4; i++) begin
			connect(0); q.push_back({1'b0, act_p[i]}); send(8'h80, 1'b0);
			send(act_m[i]); wait_on(0);
		end
		connect(0); q.push_back(9'h080); send(8'h80, 1'b0); send(8'h81); wait_on(0);
		connect(0); send(8'h80, 1'b0); q.push_back(9'h040);
		send(smph_pkg::MSG_EXT, 1'b0); send(8'h02, 1'b0);
		send(smph_pkg::EXT_WIDE_NEG, 1'b0); send(lfsr[7:0]);
		tick(4); q.push_back(9'h107);
		send(smph_pkg::MSG_EXT, 1'b0); send(8'h00, 1'b0); send(8'h02, 1'b0);
		for (int i = 0; i < 255; i++) begin
			send(lfsr[7:0], i == 254); lfsr = nxt(lfsr);
		end
		wait_on(1); q.push_back(9'h107);
		send(smph_pkg::MSG_EXT, 1'b0); send(8'h01, 1'b0); send(8'h80); wait_on(1);
		q.push_back(9'h107); send(smph_pkg::MSG_DISC); wait_on(1);
		// Known code switched off by the upper layer is refused too
		sup = 3'h3; q.push_back(9'h107);
		send(smph_pkg::MSG_EXT, 1'b0); send(8'h01, 1'b0); send(smph_pkg::EXT_WIDE_NEG); wait_on(1);
		sup = 3'h4;
		dok = 1'b1; sptr = 1'b1; lim = {27'h0, lfsr[4:0]};
		q.push_back(9'h102); q.push_back(9'h104); send(smph_pkg::MSG_DISC);
		wait_on(2); wait_on(3);
		chk(n === ((lim > DLY) ? lim : DLY) + 1, "hold length");
		wait_on(0);
		connect(1); q.push_back({3'b110, key[3], 2'b00, key[2:0]}); wait_on(1);
		q.push_back(9'h100); cmd = 1'b1; tick(1); cmd = 1'b0; wait_on(0);
		chk(bsy === 1'b0, "busy after command complete");
		// Attention during the identify leaves the nexus not fully identified
		atn_r = 1'b1; connect(1); q.push_back({3'b110, key[3], 2'b00, key[2:0]}); wait_on(1);
		q.push_back(9'h100); cmd = 1'b1; tick(1); cmd = 1'b0; wait_on(1);
		chk(bsy === 1'b1 && rdy === 1'b1, "complete taken with attention true");
		send(smph_pkg::MSG_ABORT_TAG); wait_on(0); atn_r = 1'b0;
		connect(1); q.push_back({3'b110, key[3], 2'b00, key[2:0]}); wait_on(1);
		q.push_back(9'h102); q.push_back(9'h104); dreq = 1'b1; tick(1); dreq = 1'b0; wait_on(0);
		connect(0); send(8'h80, 1'b0); en = 1'b0; send(smph_pkg::MSG_ABORT); en = 1'b1;
		chk(bsy === 1'b1 && pulse === 8'h00, "byte taken while disabled");
		bus_rst = 1'b1; tick(3);
		chk(bsy === 1'b0 && min === 1'b0, "bus reset kept busy");
		bus_rst = 1'b0; wait_on(0);
		chk(q.size() === 0, "missing results");
		end_of_test();
	end
endmodule : tb
`default_nettype wire
